// ===== cce_pkg.sv
// Shared constants and types for the clear/compare/complement slice.
// Assumes a byte-wide core and a 32-bit AHB-Lite register bus.
package cce_pkg;

   // ----------------------------------------
   // Register map and fields
   // ----------------------------------------
   localparam logic [4:0] CCE_OFF_ACC = 5'h00;
   localparam logic [4:0] CCE_OFF_IDX = 5'h04;
   localparam logic [4:0] CCE_OFF_CC = 5'h08;
   localparam logic [4:0] CCE_OFF_OP = 5'h0C;
   localparam logic [4:0] CCE_OFF_MEM = 5'h10;
   localparam logic [4:0] CCE_OFF_CTRL = 5'h14;
   localparam logic [4:0] CCE_OFF_STAT = 5'h18;
   localparam int CCE_CTRL_GO = 0;
   localparam int CCE_STAT_BUSY = 0;
   localparam int CCE_STAT_DONE = 1;
   localparam int CCE_STAT_ILL = 2;
   localparam int CCE_STAT_IRQ = 3;
   localparam int CCE_STAT_LEN = 4;
   localparam int CCE_STAT_CYC = 8;
   localparam logic [2:0] CCE_CC_ONES = 3'h7;

   // ----------------------------------------
   // Opcode fields
   // ----------------------------------------
   localparam logic [7:0] CCE_OP_CLC = 8'h98;
   localparam logic [7:0] CCE_OP_CLI = 8'h9A;
   localparam logic [3:0] CCE_HI_INH = 4'h9;
   localparam logic [3:0] CCE_HI_ACC = 4'h4;
   localparam logic [3:0] CCE_HI_IDX = 4'h5;
   localparam logic [3:0] CCE_HI_DIR = 4'h3;
   localparam logic [3:0] CCE_HI_IX0 = 4'h7;
   localparam logic [3:0] CCE_HI_IX1 = 4'h6;
   localparam logic [3:0] CCE_HI_IMM = 4'hA;
   localparam logic [3:0] CCE_HI_CDIR = 4'hB;
   localparam logic [3:0] CCE_HI_EXT = 4'hC;
   localparam logic [3:0] CCE_HI_CIX0 = 4'hF;
   localparam logic [3:0] CCE_HI_CIX1 = 4'hE;
   localparam logic [3:0] CCE_HI_CIX2 = 4'hD;
   localparam logic [3:0] CCE_LO_CLR = 4'hF;
   localparam logic [3:0] CCE_LO_COM = 4'h3;
   localparam logic [3:0] CCE_LO_CMP = 4'h1;
   localparam logic [3:0] CCE_LO_CPX = 4'h3;

   // ----------------------------------------
   // Cycle counts, HMOS and CMOS, and lengths
   // ----------------------------------------
   localparam logic [3:0] CCE_CYC_INH = 4'h2;
   localparam logic [3:0] CCE_CYC_REG_H = 4'h4;
   localparam logic [3:0] CCE_CYC_REG_C = 4'h3;
   localparam logic [3:0] CCE_CYC_RMW_H = 4'h6;
   localparam logic [3:0] CCE_CYC_RMW_C = 4'h5;
   localparam logic [3:0] CCE_CYC_RIX1_H = 4'h7;
   localparam logic [3:0] CCE_CYC_RIX1_C = 4'h6;
   localparam logic [3:0] CCE_CYC_IMM = 4'h2;
   localparam logic [3:0] CCE_CYC_SHORT_H = 4'h4;
   localparam logic [3:0] CCE_CYC_SHORT_C = 4'h3;
   localparam logic [3:0] CCE_CYC_MID_H = 4'h5;
   localparam logic [3:0] CCE_CYC_MID_C = 4'h4;
   localparam logic [3:0] CCE_CYC_IX2_H = 4'h6;
   localparam logic [3:0] CCE_CYC_IX2_C = 4'h5;
   localparam logic [1:0] CCE_LEN_1 = 2'h1;
   localparam logic [1:0] CCE_LEN_2 = 2'h2;
   localparam logic [1:0] CCE_LEN_3 = 2'h3;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {CCE_K_NONE = 3'b000, CCE_K_CLC = 3'b001, CCE_K_CLI = 3'b010,
      CCE_K_CLR = 3'b011, CCE_K_COM = 3'b100, CCE_K_CMP = 3'b101, CCE_K_CPX = 3'b110} cce_kind_t;
   typedef enum logic [1:0] {CCE_T_ACC = 2'b00, CCE_T_IDX = 2'b01, CCE_T_MEM = 2'b10} cce_tgt_t;
   typedef struct packed {logic h; logic i; logic n; logic z; logic c;} cce_cc_t;
   typedef struct packed {cce_kind_t kind; cce_tgt_t tgt; logic [3:0] cyc; logic [1:0] len; logic ok;} cce_dec_t;
   typedef struct packed {logic [7:0] res; cce_cc_t cc; logic wr;} cce_alu_t;
   typedef struct packed {logic hsel; logic [31:0] haddr; logic [1:0] htrans; logic hwrite;
      logic [2:0] hsize; logic [31:0] hwdata; logic hready;} cce_ahb_in_t;
   typedef struct packed {logic [31:0] hrdata; logic hreadyout; logic hresp;} cce_ahb_out_t;

   // Reset values.
   localparam cce_cc_t CCE_RST_CC = 5'h08;
   localparam cce_dec_t CCE_DEC_NONE = '{kind: CCE_K_NONE, tgt: CCE_T_ACC, cyc: 4'h0, len: 2'h0, ok: 1'b0};
   localparam cce_ahb_out_t CCE_AHB_RST = '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0};

endpackage

// ===== cce_alu.sv
// Result and flag logic for the six instructions.
// Assumes operands are stable for the whole cycle it is read.
`timescale 1ns/100ps
module cce_alu (
   input wire cce_pkg::cce_kind_t i_kind, // Instruction kind.
   input wire cce_pkg::cce_tgt_t i_tgt, // Operand target.
   input wire logic [7:0] i_acc, // Accumulator.
   input wire logic [7:0] i_idx, // Index register.
   input wire logic [7:0] i_mem, // Memory operand.
   input wire cce_pkg::cce_cc_t i_cc, // Flags in.
   output cce_pkg::cce_alu_t o_alu // Result, flags out, write flag.
);
   import cce_pkg::*;
   logic [7:0] opnd;
   logic [7:0] lhs;
   logic [7:0] diff;

   // Flags not named by an instruction pass through untouched.
   always_comb begin
      opnd = (i_tgt == CCE_T_ACC) ? i_acc : ((i_tgt == CCE_T_IDX) ? i_idx : i_mem);
      lhs = (i_kind == CCE_K_CPX) ? i_idx : i_acc;
      diff = lhs - i_mem;
      o_alu.res = opnd;
      o_alu.cc = i_cc;
      o_alu.wr = 1'b0;
      case (i_kind)
         CCE_K_CLC: o_alu.cc.c = 1'b0;
         CCE_K_CLI: o_alu.cc.i = 1'b0;
         CCE_K_CLR: begin
            o_alu.res = 8'h00;
            o_alu.cc.n = 1'b0;
            o_alu.cc.z = 1'b1;
            o_alu.wr = 1'b1;
         end
         CCE_K_COM: begin
            o_alu.res = ~opnd;
            o_alu.cc.n = ~opnd[7];
            o_alu.cc.z = (opnd == 8'hFF);
            o_alu.cc.c = 1'b1;
            o_alu.wr = 1'b1;
         end
         CCE_K_CMP, CCE_K_CPX: begin
            o_alu.cc.n = diff[7];
            o_alu.cc.z = (diff == 8'h00);
            o_alu.cc.c = (~lhs[7] & i_mem[7]) | (i_mem[7] & diff[7]) | (diff[7] & ~lhs[7]);
         end
         default: ;
      endcase
   end
endmodule // cce_alu

// ===== cce_timing.sv
// Opcode decoder giving kind, target, length and cycle count.
// Assumes the cycle table is fixed at build time.
`timescale 1ns/100ps
module cce_timing #(
   parameter bit P_CMOS = 1'b0 // Set for the CMOS cycle table.
) (
   input wire logic [7:0] i_op, // Opcode byte.
   output cce_pkg::cce_dec_t o_dec // Decoded instruction.
);
   import cce_pkg::*;

   // Both tables share every flag and result; only counts differ.
   function automatic logic [3:0] pick(input logic [3:0] h, input logic [3:0] c);
      return P_CMOS ? c : h;
   endfunction

   // Kind from both nibbles, then mode from the high nibble.
   always_comb begin
      o_dec = CCE_DEC_NONE;
      o_dec.tgt = CCE_T_MEM;
      case (i_op[7:4])
         CCE_HI_INH: begin
            o_dec.cyc = CCE_CYC_INH;
            o_dec.len = CCE_LEN_1;
            o_dec.ok = 1'b1;
            if (i_op == CCE_OP_CLC) begin
               o_dec.kind = CCE_K_CLC;
            end else if (i_op == CCE_OP_CLI) begin
               o_dec.kind = CCE_K_CLI;
            end else begin
               o_dec.ok = 1'b0;
            end
         end
         CCE_HI_ACC, CCE_HI_IDX, CCE_HI_DIR, CCE_HI_IX0, CCE_HI_IX1: begin
            o_dec.ok = (i_op[3:0] == CCE_LO_CLR) || (i_op[3:0] == CCE_LO_COM);
            if (i_op[3:0] == CCE_LO_CLR) begin
               o_dec.kind = CCE_K_CLR;
            end else begin
               o_dec.kind = CCE_K_COM;
            end
            o_dec.len = (i_op[7:4] == CCE_HI_ACC || i_op[7:4] == CCE_HI_IDX || i_op[7:4] == CCE_HI_IX0)
               ? CCE_LEN_1 : CCE_LEN_2;
            o_dec.cyc = pick(CCE_CYC_RMW_H, CCE_CYC_RMW_C);
            if (i_op[7:4] == CCE_HI_ACC || i_op[7:4] == CCE_HI_IDX) begin
               o_dec.cyc = pick(CCE_CYC_REG_H, CCE_CYC_REG_C);
            end else if (i_op[7:4] == CCE_HI_IX1) begin
               o_dec.cyc = pick(CCE_CYC_RIX1_H, CCE_CYC_RIX1_C);
            end
            if (i_op[7:4] == CCE_HI_ACC) begin
               o_dec.tgt = CCE_T_ACC;
            end else if (i_op[7:4] == CCE_HI_IDX) begin
               o_dec.tgt = CCE_T_IDX;
            end
         end
         CCE_HI_IMM, CCE_HI_CDIR, CCE_HI_EXT, CCE_HI_CIX0, CCE_HI_CIX1, CCE_HI_CIX2: begin
            o_dec.ok = (i_op[3:0] == CCE_LO_CMP) || (i_op[3:0] == CCE_LO_CPX);
            if (i_op[3:0] == CCE_LO_CMP) begin
               o_dec.kind = CCE_K_CMP;
            end else begin
               o_dec.kind = CCE_K_CPX;
            end
            case (i_op[7:4])
               CCE_HI_IMM: o_dec.cyc = CCE_CYC_IMM;
               CCE_HI_CDIR, CCE_HI_CIX0: o_dec.cyc = pick(CCE_CYC_SHORT_H, CCE_CYC_SHORT_C);
               CCE_HI_EXT, CCE_HI_CIX1: o_dec.cyc = pick(CCE_CYC_MID_H, CCE_CYC_MID_C);
               default: o_dec.cyc = pick(CCE_CYC_IX2_H, CCE_CYC_IX2_C);
            endcase
            o_dec.len = (i_op[7:4] == CCE_HI_CIX0) ? CCE_LEN_1
               : ((i_op[7:4] == CCE_HI_EXT || i_op[7:4] == CCE_HI_CIX2) ? CCE_LEN_3 : CCE_LEN_2);
         end
         default: ;
      endcase
      if (!o_dec.ok) begin
         o_dec = CCE_DEC_NONE;
      end
   end
endmodule // cce_timing

// ===== cce_exec.sv
// Execution slice for the clear, compare and complement instructions,
// with its registers on an AHB-Lite slave port.
// Assumes one AHB-Lite master doing single word transfers, and an
// interrupt request pin from outside the core clock domain.
//
// Overview of operation
// - Clear-carry 98 clears C only, two cycles.
// - Clear-mask 9A clears I only, two cycles.
// - Pending interrupts are honoured once I clears.
// - Clear writes zero, N cleared, Z set.
// - Clear opcodes 4F 5F 3F 7F 6F timing.
// - Compares set flags only, operands untouched.
// - Compare N is bit seven, Z on zero.
// - Accumulator compare carry is unsigned borrow.
// - Accumulator compare opcodes A1 to D1 timing.
// - Index compare carry is unsigned borrow.
// - Index compare opcodes A3 to D3 timing.
// - Complement inverts operand, sets N Z, sets C.
// - Complement opcodes 43 53 33 73 63 timing.
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module cce_exec #(
   parameter bit P_CMOS = 1'b0 // Set for the CMOS cycle table.
) (
   input wire logic i_mclk, // Core clock.
   input wire logic i_rst_n, // Asynchronous reset.
   input wire cce_pkg::cce_ahb_in_t i_ahb, // Bus request.
   input wire logic i_irq_req, // Interrupt pin.
   output cce_pkg::cce_ahb_out_t o_ahb, // Bus answer.
   output logic o_irq_service, // Interrupt may be taken.
   output logic o_busy // Instruction running.
);
   import cce_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------

   // The whole slice state; one copy is next, one is registered.
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] idx;
      logic [7:0] mem;
      logic [7:0] op;
      cce_cc_t cc;
      logic busy;
      logic done;
      logic illegal;
      logic [3:0] cnt;
      cce_dec_t dec;
      logic ph_act;
      logic ph_wr;
      logic [4:0] ph_addr;
      logic [2:0] sync;
      logic irq_lvl;
      logic irq_svc;
      cce_ahb_out_t ahb;
   } cce_state_t;

   localparam cce_state_t CCE_RST = '{
      cc: CCE_RST_CC,
      dec: CCE_DEC_NONE,
      ahb: CCE_AHB_RST,
      default: '0
   };

   cce_state_t r;
   cce_state_t s;
   cce_dec_t dec;
   cce_alu_t alu;
   logic fin;
   logic go;
   logic wr_stat;
   logic [7:0] cmp_diff;

   // ----------------------------------------
   // Read multiplexer
   // ----------------------------------------

   // Upper bits of each word read as zero.
   function automatic logic [31:0] rd_word(input cce_state_t t, input logic [4:0] a);
      logic [31:0] w;
      w = 32'h0;
      case (a)
         CCE_OFF_ACC: w[7:0] = t.acc;
         CCE_OFF_IDX: w[7:0] = t.idx;
         CCE_OFF_CC: w[7:0] = {CCE_CC_ONES, t.cc};
         CCE_OFF_OP: w[7:0] = t.op;
         CCE_OFF_MEM: w[7:0] = t.mem;
         CCE_OFF_STAT: begin
            w[CCE_STAT_BUSY] = t.busy;
            w[CCE_STAT_DONE] = t.done;
            w[CCE_STAT_ILL] = t.illegal;
            w[CCE_STAT_IRQ] = t.irq_svc;
            w[CCE_STAT_LEN +: 2] = t.dec.len;
            w[CCE_STAT_CYC +: 4] = t.dec.cyc;
         end
         default: ;
      endcase
      return w;
   endfunction

   // ----------------------------------------
   // Decoder and result logic
   // ----------------------------------------

   // Decode the opcode register; the result is latched at start.
   cce_timing #(
      .P_CMOS(P_CMOS)
   ) u_timing (
      .i_op(r.op),
      .o_dec(dec)
   );

   // Results are computed from the latched kind and frozen operands.
   cce_alu u_alu (
      .i_kind(r.dec.kind),
      .i_tgt(r.dec.tgt),
      .i_acc(r.acc),
      .i_idx(r.idx),
      .i_mem(r.mem),
      .i_cc(r.cc),
      .o_alu(alu)
   );

   // Last cycle of a running instruction, and an accepted start.
   assign fin = r.busy && (r.cnt == 4'h0);
   assign wr_stat = r.ph_act && r.ph_wr && (r.ph_addr == CCE_OFF_STAT);
   assign go = r.ph_act && r.ph_wr && (r.ph_addr == CCE_OFF_CTRL) && i_ahb.hwdata[CCE_CTRL_GO] && !r.busy;
   assign cmp_diff = ((r.dec.kind == CCE_K_CPX) ? r.idx : r.acc) - r.mem;

   // ----------------------------------------
   // Next state
   // ----------------------------------------

   always_comb begin
      s = r;

      // Operand and flag writes are dropped while an instruction runs,
      // so the result never mixes old and new operands.
      if (r.ph_act && r.ph_wr && !r.busy) begin
         case (r.ph_addr)
            CCE_OFF_ACC: s.acc = i_ahb.hwdata[7:0];
            CCE_OFF_IDX: s.idx = i_ahb.hwdata[7:0];
            CCE_OFF_CC: s.cc = i_ahb.hwdata[4:0];
            CCE_OFF_OP: s.op = i_ahb.hwdata[7:0];
            CCE_OFF_MEM: s.mem = i_ahb.hwdata[7:0];
            default: ;
         endcase
      end

      // Status flags clear by writing one; a hardware set below wins.
      if (wr_stat && i_ahb.hwdata[CCE_STAT_DONE]) begin
         s.done = 1'b0;
      end
      if (wr_stat && i_ahb.hwdata[CCE_STAT_ILL]) begin
         s.illegal = 1'b0;
      end

      // Start: latch the decode and load the cycle counter.
      if (go) begin
         if (dec.ok) begin
            s.busy = 1'b1;
            s.dec = dec;
            s.cnt = dec.cyc - 4'h1;
         end else begin
            s.illegal = 1'b1;
         end
      end

      // Countdown; results and flags land on the last cycle.
      if (fin) begin
         s.busy = 1'b0;
         s.done = 1'b1;
         s.cc = alu.cc;
         if (alu.wr) begin
            case (r.dec.tgt)
               CCE_T_ACC: s.acc = alu.res;
               CCE_T_IDX: s.idx = alu.res;
               default: s.mem = alu.res;
            endcase
         end
      end else if (r.busy) begin
         s.cnt = r.cnt - 4'h1;
      end

      // Interrupt pin: a change counts once the last two stages agree.
      s.sync = {r.sync[1:0], i_irq_req};
      if (r.sync[1] == r.sync[2]) begin
         s.irq_lvl = r.sync[2];
      end
      s.irq_svc = r.irq_lvl && !r.cc.i && !r.busy;

      // Address phase capture; anything outside the map is ignored.
      s.ph_act = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready && (i_ahb.haddr[31:5] == 27'h0);
      s.ph_wr = i_ahb.hwrite;
      s.ph_addr = i_ahb.haddr[4:0];

      // Zero wait state: read data is the state as it will stand
      // after this edge, so a read just after a write sees the write.
      s.ahb.hreadyout = 1'b1;
      s.ahb.hresp = 1'b0;
      s.ahb.hrdata = 32'h0;
      if (s.ph_act && !s.ph_wr) begin
         s.ahb.hrdata = rd_word(s, s.ph_addr);
      end
   end

   // ----------------------------------------
   // Registers and outputs
   // ----------------------------------------

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= CCE_RST;
      end else begin
         r <= s;
      end
   end

   // Every output is a field of the registered state.
   assign o_ahb = r.ahb;
   assign o_irq_service = r.irq_svc;
   assign o_busy = r.busy;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   // Carry clear touches nothing else.
   clc_carry_a: assert property (fin && r.dec.kind == CCE_K_CLC |=> !r.cc.c
      && {r.cc.h, r.cc.i, r.cc.n, r.cc.z} == $past({r.cc.h, r.cc.i, r.cc.n, r.cc.z}))
      else $error("Carry clear changed another flag.");

   clc_time_a: assert property (go && r.op == CCE_OP_CLC |=> r.busy[*2] ##1 !r.busy)
      else $error("Carry clear did not take two cycles.");

   // Mask clear touches nothing else.
   cli_mask_a: assert property (fin && r.dec.kind == CCE_K_CLI |=> !r.cc.i
      && {r.cc.h, r.cc.n, r.cc.z, r.cc.c} == $past({r.cc.h, r.cc.n, r.cc.z, r.cc.c}))
      else $error("Mask clear changed another flag.");

   // A settled request is offered two edges after a mask clear ends.
   irq_honour_a: assert property (fin && r.dec.kind == CCE_K_CLI && r.irq_lvl && (&r.sync[2:1])
      |=> ##1 o_irq_service)
      else $error("Pending interrupt not offered with mask clear.");

   irq_masked_a: assert property (r.cc.i |=> !o_irq_service)
      else $error("Interrupt offered while masked.");

   // Clear gives zero and the fixed flags.
   clr_flags_a: assert property (fin && r.dec.kind == CCE_K_CLR |=> !r.cc.n && r.cc.z
      && r.cc.c == $past(r.cc.c) && r.cc.h == $past(r.cc.h) && r.cc.i == $past(r.cc.i))
      else $error("Clear set wrong flags.");

   clr_value_a: assert property (fin && r.dec.kind == CCE_K_CLR && r.dec.tgt == CCE_T_ACC |=> r.acc == 8'h00)
      else $error("Clear left accumulator non-zero.");

   clr_time_h_a: assert property (go && r.op == {CCE_HI_ACC, CCE_LO_CLR} && !P_CMOS
      |=> r.busy[*4] ##1 !r.busy)
      else $error("Accumulator clear not four cycles.");

   clr_time_c_a: assert property (go && r.op == {CCE_HI_ACC, CCE_LO_CLR} && P_CMOS
      |=> r.busy[*3] ##1 !r.busy)
      else $error("Accumulator clear not three cycles.");

   // Compares keep every operand and the H and I flags.
   cmp_keep_a: assert property (fin && r.dec.kind inside {CCE_K_CMP, CCE_K_CPX}
      |=> $stable(r.acc) && $stable(r.idx) && $stable(r.mem) && $stable(r.cc.h) && $stable(r.cc.i))
      else $error("Compare disturbed an operand or flag.");

   cmp_nz_a: assert property (fin && r.dec.kind inside {CCE_K_CMP, CCE_K_CPX}
      |=> r.cc.n == $past(cmp_diff[7]) && r.cc.z == ($past(cmp_diff) == 8'h00))
      else $error("Compare N or Z wrong.");

   cmp_carry_a: assert property (fin && r.dec.kind == CCE_K_CMP
      |=> r.cc.c == ($past(r.mem) > $past(r.acc)))
      else $error("Accumulator compare carry wrong.");

   cmp_time_a: assert property (go && r.op == {CCE_HI_CDIR, CCE_LO_CMP} && !P_CMOS
      |=> r.busy[*4] ##1 !r.busy)
      else $error("Direct compare not four cycles.");

   cpx_carry_a: assert property (fin && r.dec.kind == CCE_K_CPX
      |=> r.cc.c == ($past(r.mem) > $past(r.idx)))
      else $error("Index compare carry wrong.");

   cpx_time_a: assert property (go && r.op == {CCE_HI_CIX2, CCE_LO_CPX} && !P_CMOS
      |=> r.busy[*6] ##1 !r.busy)
      else $error("Index compare long offset not six cycles.");

   // Complement of the index register.
   com_result_a: assert property (fin && r.dec.kind == CCE_K_COM && r.dec.tgt == CCE_T_IDX
      |=> r.idx == ~$past(r.idx) && r.cc.c && r.cc.n == r.idx[7] && r.cc.z == (r.idx == 8'h00))
      else $error("Complement result or flags wrong.");

   com_time_a: assert property (go && r.op == {CCE_HI_IX1, CCE_LO_COM} && !P_CMOS
      |=> r.busy[*7] ##1 !r.busy)
      else $error("Offset complement not seven cycles.");

   // Mask clear takes two cycles on either table.
   cli_time_a: assert property (go && r.op == CCE_OP_CLI
      |=> r.busy[*2] ##1 !r.busy)
      else $error("Mask clear did not take two cycles.");

   // Clear of the memory operand leaves zero there.
   clr_mem_a: assert property (fin && r.dec.kind == CCE_K_CLR && r.dec.tgt == CCE_T_MEM
      |=> r.mem == 8'h00)
      else $error("Clear left memory operand non-zero.");

   // Immediate compare is two cycles on either table.
   cmp_imm_a: assert property (go && r.op == {CCE_HI_IMM, CCE_LO_CMP}
      |=> r.busy[*2] ##1 !r.busy)
      else $error("Immediate compare not two cycles.");

   // Immediate index compare is two cycles on either table.
   cpx_imm_a: assert property (go && r.op == {CCE_HI_IMM, CCE_LO_CPX}
      |=> r.busy[*2] ##1 !r.busy)
      else $error("Immediate index compare not two cycles.");

   // Accumulator complement inverts and always sets carry.
   com_acc_a: assert property (fin && r.dec.kind == CCE_K_COM && r.dec.tgt == CCE_T_ACC
      |=> r.acc == ~$past(r.acc) && r.cc.c)
      else $error("Accumulator complement wrong.");

   // The CMOS table saves a cycle on the long index compare.
   cpx_time_c_a: assert property (go && r.op == {CCE_HI_CIX2, CCE_LO_CPX} && P_CMOS
      |=> r.busy[*5] ##1 !r.busy)
      else $error("Index compare long offset not five cycles.");

   // Main scenarios.
   cmp_done_c: cover property (fin && r.dec.kind == CCE_K_CMP);
   com_mem_c: cover property (fin && r.dec.kind == CCE_K_COM && r.dec.tgt == CCE_T_MEM);
   irq_take_c: cover property (fin && r.dec.kind == CCE_K_CLI ##[1:4] o_irq_service);
   bad_op_c: cover property (go && !dec.ok);

endmodule // cce_exec

// ===== cce_mem_model.sv
// Behavioural program memory that hands the bench one opcode per test slot.
// Assumes the bench only asks for slots 0 to 23.
`timescale 1ns/100ps
module cce_mem_model (
   input wire logic [4:0] i_slot, // Test slot.
   output logic [7:0] o_op // Opcode held at that slot.
);
   // Every documented encoding once, so one pass of the slots reaches them all.
   localparam logic [7:0] ROM [24] = '{8'h98, 8'h9A,
      8'h4F, 8'h5F, 8'h3F, 8'h7F, 8'h6F,
      8'h43, 8'h53, 8'h33, 8'h73, 8'h63,
      8'hA1, 8'hB1, 8'hC1, 8'hF1, 8'hE1, 8'hD1,
      8'hA3, 8'hB3, 8'hC3, 8'hF3, 8'hE3, 8'hD3};
   // Slots past the table would read as unknown, so the bench wraps its index.
   assign o_op = ROM[i_slot];
endmodule // cce_mem_model

// ===== clear_compare_complement_exec_tb.sv
// Self-checking bench for the execution slice over its AHB-Lite port.
// Assumes a zero-wait slave; a second instance runs the CMOS table.
`timescale 1ns/100ps
module clear_compare_complement_exec_tb;
   import cce_pkg::*;
   typedef struct packed {logic [7:0] a; logic [7:0] x; logic [7:0] m; logic [4:0] cc;
      logic [3:0] cyc; logic [1:0] len;} cce_exp_t;
   localparam bit P_CMOS = 1'b0;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_irq_req = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rdv;
   logic [31:0] seed = 32'h71EB70B9;
   logic [4:0] slot = 5'h0;
   logic [7:0] op;
   cce_ahb_in_t ahb_in;
   cce_ahb_out_t o_ahb;
   logic o_irq_service;
   logic o_busy;
   cce_ahb_out_t o_ahb_c;
   logic o_irq_service_c;
   logic o_busy_c;
   logic [31:0] rdv_c;
   int err_total = 0;
   int checks_done = 0;
   // The bus hready is the HMOS slave's hreadyout.
   assign ahb_in = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2,
      hwdata: hwdata, hready: o_ahb.hreadyout};
   // Core clock at 100 MHz.
   always #5 i_mclk = ~i_mclk;
   cce_exec #(.P_CMOS(P_CMOS)) i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ahb(ahb_in),
      .i_irq_req(i_irq_req), .o_ahb(o_ahb), .o_irq_service(o_irq_service), .o_busy(o_busy));
   cce_exec #(.P_CMOS(1'b1)) i_dut_c (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ahb(ahb_in),
      .i_irq_req(i_irq_req), .o_ahb(o_ahb_c), .o_irq_service(o_irq_service_c), .o_busy(o_busy_c));
   cce_mem_model i_mem (.i_slot(slot), .o_op(op));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Expected registers, flags, length and cycles of one instruction.
   function automatic cce_exp_t model(input logic [7:0] op, input cce_exp_t e);
      logic [7:0] v;
      logic [7:0] r;
      logic [3:0] hi;
      hi = op[7:4];
      e.cyc = 4'h2;
      e.len = 2'h1;
      if (op == 8'h98) begin
         e.cc[0] = 1'b0;
      end else if (op == 8'h9A) begin
         e.cc[3] = 1'b0;
      end else if (!op[7]) begin
         v = (hi == 4'h4) ? e.a : ((hi == 4'h5) ? e.x : e.m);
         r = (op[3:0] == 4'hF) ? 8'h00 : ~v;
         e.cc[2:0] = {r[7], r == 8'h00, (op[3:0] == 4'hF) ? e.cc[0] : 1'b1};
         if (hi == 4'h4) e.a = r;
         else if (hi == 4'h5) e.x = r;
         else e.m = r;
         e.cyc = (hi == 4'h4 || hi == 4'h5) ? 4'h4 : ((hi == 4'h6) ? 4'h7 : 4'h6);
         e.len = (hi == 4'h3 || hi == 4'h6) ? 2'h2 : 2'h1;
      end else begin
         v = op[1] ? e.x : e.a;
         r = v - e.m;
         e.cc[2:0] = {r[7], r == 8'h00, e.m > v};
         e.cyc = (hi == 4'hA) ? 4'h2 : ((hi == 4'hB || hi == 4'hF) ? 4'h4 : ((hi == 4'hD) ? 4'h6 : 4'h5));
         e.len = (hi == 4'hF) ? 2'h1 : ((hi == 4'hC || hi == 4'hD) ? 2'h3 : 2'h2);
      end
      if (e.cyc > 4'h2) e.cyc = e.cyc - 4'(P_CMOS);
      return e;
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One single transfer; the address and data phases are each held until hready.
   task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {27'h0, a};
      hwrite <= w;
      do @(posedge i_mclk); while (o_ahb.hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge i_mclk); while (o_ahb.hreadyout !== 1'b1);
      rdv = o_ahb.hrdata;
      rdv_c = o_ahb_c.hrdata;
   endtask
   task rc(input logic [4:0] a, input logic [11:0] x);
      bus(1'b0, a, 8'h00);
      chk(rdv, {20'h0, x});
      chk(32'(o_ahb.hresp), 32'h0);
      if (a != CCE_OFF_STAT) chk(rdv_c, {20'h0, x});
   endtask
   task give_verdict;
      $display("Checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Watchdog: the tests need about 19 us, so 200 us means a hang.
   initial begin
      #200000;
      err_total++;
      give_verdict();
   end
   // Main sequence: two passes over all opcodes, random then equal operands.
   initial begin
      cce_exp_t e;
      int cnt;
      int cnt_c;
      repeat (20) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      rc(CCE_OFF_CC, 12'h0E8);
      bus(1'b1, 5'h1C, 8'h55);
      rc(5'h1C, 12'h000);
      for (int k = 0; k < 48; k++) begin
         slot = 5'(k % 24);
         seed = xs(seed);
         e = {seed[23:0], seed[28:24], 6'h0};
         i_irq_req <= seed[31];
         // Equal operands are the corner where compares give zero and no borrow.
         if (k >= 24) e.x = e.a;
         if (k >= 24) e.m = e.a;
         bus(1'b1, CCE_OFF_ACC, e.a);
         bus(1'b1, CCE_OFF_IDX, e.x);
         bus(1'b1, CCE_OFF_MEM, e.m);
         bus(1'b1, CCE_OFF_CC, {3'h0, e.cc});
         bus(1'b1, CCE_OFF_OP, op);
         bus(1'b1, CCE_OFF_CTRL, 8'h01);
         cnt = 0;
         cnt_c = 0;
         #1;
         while ((o_busy === 1'b1 || o_busy_c === 1'b1) && cnt + cnt_c < 40) begin
            cnt += int'(o_busy === 1'b1);
            cnt_c += int'(o_busy_c === 1'b1);
            @(posedge i_mclk);
            #1;
         end
         e = model(op, e);
         chk(32'(cnt), 32'(e.cyc));
         chk(32'(cnt_c), 32'(e.cyc - 4'(e.cyc > 4'h2)));
         rc(CCE_OFF_ACC, 12'(e.a));
         rc(CCE_OFF_IDX, 12'(e.x));
         rc(CCE_OFF_MEM, 12'(e.m));
         rc(CCE_OFF_CC, {4'h0, 3'h7, e.cc});
         rc(CCE_OFF_STAT, {e.cyc, 2'b00, e.len, seed[31] & ~e.cc[3], 3'b010});
         chk(32'(o_irq_service), 32'(seed[31] & ~e.cc[3]));
         chk(32'(o_irq_service_c), 32'(seed[31] & ~e.cc[3]));
         $display("Test %0d opcode %h done", k, op);
      end
      // An undecodable opcode is refused and flagged; writing ones clears the flags.
      bus(1'b1, CCE_OFF_OP, 8'h99);
      bus(1'b1, CCE_OFF_CTRL, 8'h01);
      rc(CCE_OFF_STAT, {e.cyc, 2'b00, e.len, seed[31] & ~e.cc[3], 3'b110});
      bus(1'b1, CCE_OFF_STAT, 8'h06);
      rc(CCE_OFF_STAT, {e.cyc, 2'b00, e.len, seed[31] & ~e.cc[3], 3'b000});
      $display("Test illegal opcode done");
      give_verdict();
   end
endmodule // clear_compare_complement_exec_tb
